// [hw/maint_decode.sv]
// Decoder that turns the two maintenance instructions and the accumulator into pulses.
`timescale 1ns/1ps
module maint_decode #(
   parameter bit EIGHT_MODE = 1'b1
) (
   maint_if.decoder m
);
   // Accumulator bit 00 is the most significant bit of the word.
   function automatic logic acb(input logic [11:0] ac, input int n);
      acb = ac[11 - n];
   endfunction

   always_comb begin
      m.load_mir  = m.iot_first;
      m.clr_done  = m.iot_first & acb(m.ac, 4);
      m.skip_test = m.iot_first & acb(m.ac, 5);
      m.tp0       = m.iot_first & acb(m.ac, 6);
      m.tp3       = m.iot_first & acb(m.ac, 7);
      m.sim_val   = m.ac[3:0];
      for (int i = 0; i < 12; i++) begin
         // Only the 8-mode variant has the upper control functions.
         m.ctl_pulse[i] = m.iot_second & acb(m.ac, i) & ((i < 4) | EIGHT_MODE);
      end
   end
endmodule

// [hw/maint_if.sv]
// Carrier between the instruction decoder and the maintenance port core.
`timescale 1ns/1ps
interface maint_if;
   logic        iot_first;
   logic        iot_second;
   logic [11:0] ac;
   logic        load_mir;
   logic        clr_done;
   logic        skip_test;
   logic        tp0;
   logic        tp3;
   logic [3:0]  sim_val;
   logic [11:0] ctl_pulse;
   modport decoder (input iot_first, iot_second, ac,
                    output load_mir, clr_done, skip_test, tp0, tp3, sim_val, ctl_pulse);
   modport core (output iot_first, iot_second, ac,
                 input load_mir, clr_done, skip_test, tp0, tp3, sim_val, ctl_pulse);
endinterface

// [hw/tape_control_maintenance_port.sv]
// Maintenance port of the tape control unit behind an Avalon-MM register slave.
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "tape_maint_defines.svh"
module tape_control_maintenance_port
   import tape_maint_pkg::*;
#(
   parameter bit EIGHT_MODE = 1'b1
) (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        ce_i,
   input  wire logic [4:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        xport_mark_i,
   input  wire logic [2:0]  xport_data_i,
   input  wire logic        xport_done_i,
   output logic             chan_mark_o,
   output logic      [2:0]  chan_data_o,
   output logic             timing_pulse_zero_o,
   output logic             timing_pulse_three_o,
   output logic             skip_o,
   output logic             tape_preset_o,
   output logic             motion_o,
   output logic             direction_o,
   output logic             unit1_sel_o,
   output logic             write_sync_o,
   output logic             eight_tape_o,
   output logic             eight_write_o,
   output logic             irq_o
);

   state_s st_reg;
   state_s st_next;
   maint_if m ();

   logic        req;
   logic        exec;
   logic        do_write;
   logic [31:0] wd;
   logic [11:0] ac;
   logic [4:0]  pins;
   logic        done_rise;
   logic [2:0]  events;
   logic [31:0] rd_value;

   maint_decode #(
      .EIGHT_MODE (EIGHT_MODE)
   ) u_decode (
      .m (m)
   );

   // Byte lanes not enabled write as zero into the 12-bit fields.
   function automatic logic [31:0] lane_mask(input logic [31:0] d, input logic [3:0] be);
      lane_mask = d & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   // Zero-extends a 12-bit tape word into a bus word.
   function automatic logic [31:0] ext12(input logic [11:0] w);
      ext12 = {20'h00000, w};
   endfunction

   // Value placed on the tape bus for a readback, selected by the instruction register.
   function automatic logic [11:0] tape_bus(input state_s s);
      case (s.mir)
         `SEL_READ_SETUP: tape_bus = s.tma;
         `SEL_READ_TBN:   tape_bus = s.tbn;
         `SEL_READ_TB:    tape_bus = s.tb;
         `SEL_READ_RWB:   tape_bus = s.read_write_buffer;
         `SEL_READ_UNITS: tape_bus = {s.unit1, ~s.unit1, 6'h3F, s.motion, s.backward,
                                      1'b0, s.write_sync};
         // Only the all-ones test of the tape accumulator is shown in this view.
         `SEL_READ_CTL:   tape_bus = {(s.tape_accumulator_register == 12'hFFF), 11'h000};
         `SEL_READ_TMA:   tape_bus = s.tma;
         default:         tape_bus = 12'h000;
      endcase
   endfunction

   always_comb begin
      req       = avs_read_i | avs_write_i;
      // A request takes effect on the edge at which waitrequest is seen low.
      exec      = req & (st_reg.phase == BUS_ACK);
      do_write  = exec & avs_write_i;
      wd        = lane_mask(avs_writedata_i, avs_byteenable_i);
      ac        = wd[11:0];
      pins      = {xport_done_i, xport_mark_i, xport_data_i};

      m.iot_first  = do_write & (avs_address_i == `ADDR_IOT_FIRST);
      m.iot_second = do_write & (avs_address_i == `ADDR_IOT_SECOND);
      m.ac         = ac;

      case (avs_address_i)
         `ADDR_IOT_FIRST:  rd_value = {31'h00000000, st_reg.last_skip};
         `ADDR_IOT_SECOND: rd_value = 32'h00000000;
         `ADDR_STATUS:     rd_value = {9'h000, st_reg.eight_write, st_reg.eight_tape,
                                       st_reg.eight_block, st_reg.write_sync, st_reg.unit1,
                                       st_reg.backward, st_reg.motion, st_reg.chan,
                                       st_reg.sim, st_reg.done, 3'h0, st_reg.mir};
         `ADDR_CTRL:       rd_value = {31'h00000000, st_reg.maint};
         `ADDR_IRQ_STAT:   rd_value = {29'h00000000, st_reg.irq_stat};
         `ADDR_IRQ_MASK:   rd_value = {29'h00000000, st_reg.irq_mask};
         `ADDR_XFER:       rd_value = ext12(tape_bus(st_reg));
         default:          rd_value = 32'h00000000;
      endcase

      st_next = st_reg;

      // Bus handshake: one wait cycle, then one acknowledge cycle per request.
      if (st_reg.phase == BUS_WAIT) begin
         if (req) begin
            st_next.phase = BUS_ACK;
            st_next.rdata = avs_read_i ? rd_value : 32'h00000000;
         end
      end else begin
         st_next.phase = BUS_WAIT;
         st_next.rdata = 32'h00000000;
      end

      // Pin synchronisers; a change counts once the second and third stages agree.
      st_next.s1 = pins;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      for (int i = 0; i < 5; i++) begin
         if (st_reg.s2[i] == st_reg.s3[i]) begin
            st_next.filt[i] = st_reg.s3[i];
         end
      end
      // The transport done signal is ignored while the transport is inhibited.
      done_rise = st_reg.s3[4] & ~st_reg.filt[4] & (st_reg.s2[4] == st_reg.s3[4])
                  & ~st_reg.maint;

      // Channel levels seen by the control come from software in maintenance mode.
      if (st_reg.maint) begin
         st_next.chan = st_reg.sim;
      end else begin
         st_next.chan = st_reg.filt[3:0];
      end

      // Pulses last one cycle.
      st_next.skip   = 1'b0;
      st_next.tp0    = 1'b0;
      st_next.tp3    = 1'b0;
      st_next.preset = 1'b0;

      if (do_write & (avs_address_i == `ADDR_CTRL)) begin
         st_next.maint = wd[`CTRL_MAINT_BIT];
      end
      if (do_write & (avs_address_i == `ADDR_IRQ_MASK)) begin
         st_next.irq_mask = wd[`IRQ_WIDTH-1:0];
      end

      // First instruction: every selected action happens in this one cycle.
      if (m.load_mir) begin
         st_next.mir = ac[11:8];
         st_next.sim = m.sim_val;
         // The skip sees the flag before this instruction's own clear.
         st_next.skip      = m.skip_test & st_reg.done;
         st_next.last_skip = m.skip_test & st_reg.done;
         st_next.tp0       = m.tp0;
         st_next.tp3       = m.tp3;
      end
      // Timing pulse three strobes the channel data into the tape buffer.
      if (m.tp3) begin
         st_next.tb = {st_reg.tb[8:0], st_reg.chan[2:0]};
      end
      if (m.clr_done) begin
         st_next.done = 1'b0;
      end

      // Second instruction: each set bit is its own control pulse.
      if (m.ctl_pulse[`AC_PRESET]) begin
         st_next.preset      = 1'b1;
         st_next.motion      = 1'b0;
         st_next.backward    = 1'b0;
         st_next.write_sync  = 1'b0;
         st_next.eight_block = 1'b0;
         st_next.done        = 1'b0;
      end
      if (m.ctl_pulse[`AC_SHIFT_RWB]) begin
         st_next.read_write_buffer = {st_reg.read_write_buffer[8:0], st_reg.chan[2:0]};
      end
      if (m.ctl_pulse[`AC_TB_TO_RWB]) begin
         st_next.read_write_buffer = st_reg.tb;
      end
      if (m.ctl_pulse[`AC_ADD_TAC]) begin
         st_next.tape_accumulator_register = st_reg.tb + st_reg.tape_accumulator_register;
      end
      if (m.ctl_pulse[`AC_CLR_BLOCK]) begin
         st_next.eight_block = 1'b0;
      end
      if (m.ctl_pulse[`AC_BACKWARD]) begin
         st_next.backward = 1'b1;
      end
      if (m.ctl_pulse[`AC_UNIT1]) begin
         st_next.unit1 = 1'b1;
      end
      if (m.ctl_pulse[`AC_FORWARD]) begin
         st_next.backward = 1'b0;
      end
      if (m.ctl_pulse[`AC_WRITE_SYNC]) begin
         st_next.write_sync = 1'b1;
      end
      if (m.ctl_pulse[`AC_MOTION]) begin
         st_next.motion = 1'b1;
         if (!st_reg.motion) begin
            st_next.backward = 1'b0;
         end
      end
      if (m.ctl_pulse[`AC_EIGHT_TAPE]) begin
         st_next.eight_tape = 1'b1;
      end
      if (m.ctl_pulse[`AC_EIGHT_WRITE]) begin
         st_next.eight_write = ac[0];
      end

      // Loads through the transfer register, chosen by the instruction register.
      if (do_write & (avs_address_i == `ADDR_XFER)) begin
         case (st_reg.mir)
            `SEL_LOAD_TB:  st_next.tb  = ac;
            `SEL_LOAD_TBN: st_next.tbn = ac;
            `SEL_LOAD_TAC: st_next.tape_accumulator_register = ac;
            `SEL_LOAD_TMA: st_next.tma = ac;
            default:       st_next.tma = st_reg.tma;
         endcase
      end

      // A done event arriving with a software clear still leaves the flag set.
      if (done_rise) begin
         st_next.done = 1'b1;
      end

      // Interrupt status: write one to clear, but a new event in the same cycle wins.
      events = {m.tp0 | m.tp3, |m.ctl_pulse, done_rise};
      if (do_write & (avs_address_i == `ADDR_IRQ_STAT)) begin
         st_next.irq_stat = st_reg.irq_stat & ~wd[`IRQ_WIDTH-1:0];
      end
      st_next.irq_stat = st_next.irq_stat | events;
      st_next.irq      = |(st_next.irq_stat & st_next.irq_mask);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg             <= '0;
         st_reg.phase       <= BUS_WAIT;
         st_reg.maint       <= `CTRL_RESET;
      end else if (ce_i) begin
         st_reg <= st_next;
      end
   end

   // Waitrequest stays high except during the single acknowledge cycle.
   assign avs_waitrequest_o    = (st_reg.phase == BUS_WAIT);
   assign avs_readdata_o       = st_reg.rdata;
   assign chan_mark_o          = st_reg.chan[3];
   assign chan_data_o          = st_reg.chan[2:0];
   assign timing_pulse_zero_o  = st_reg.tp0;
   assign timing_pulse_three_o = st_reg.tp3;
   assign skip_o               = st_reg.skip;
   assign tape_preset_o        = st_reg.preset;
   assign motion_o             = st_reg.motion;
   assign direction_o          = st_reg.backward;
   assign unit1_sel_o          = st_reg.unit1;
   assign write_sync_o         = st_reg.write_sync;
   assign eight_tape_o         = st_reg.eight_tape;
   assign eight_write_o        = st_reg.eight_write;
   assign irq_o                = st_reg.irq;

endmodule

// [hw/tape_maint_defines.svh]
// Offsets, field positions, reset values and bit numbers of the tape maintenance port.
// What this block does
// - In maintenance mode, transport inputs are blocked; channel inputs come from software.
// - First instruction copies accumulator bits 00-03 into the maintenance instruction register.
// - First instruction with accumulator bit 04 set clears the tape done flag.
// - First instruction with bit 05 set and done flag set requests a skip.
// - First instruction emits timing pulse zero on bit 06, three on bit 07.
// - First instruction drives bits 08-11 as simulated mark and data channel levels.
// - Second instruction gates each accumulator bit into its own control pulse.
// - Bits 00-03: preset, shift buffer, tape buffer to buffer, add into accumulator.
// - Bit 05 backward, bit 07 forward, bit 09 motion plus forward if stopped.
// - Bit 04 clear block, 06 unit 1, 08 write sync, 10 8-tape, 11 8-write.
// - Instruction register value 00-17 octal selects the register for readback or load.
// - Second-instruction functions on bits 04-11 exist only in the 8-mode control variant.
`ifndef TAPE_MAINT_DEFINES_SVH
`define TAPE_MAINT_DEFINES_SVH
`define ADDR_IOT_FIRST   5'h00
`define ADDR_IOT_SECOND  5'h04
`define ADDR_STATUS      5'h08
`define ADDR_CTRL        5'h0C
`define ADDR_IRQ_STAT    5'h10
`define ADDR_IRQ_MASK    5'h14
`define ADDR_XFER        5'h18
`define CTRL_MAINT_BIT   0
`define CTRL_RESET       1'h0
`define IRQ_DONE_BIT     0
`define IRQ_CTL_BIT      1
`define IRQ_TIMING_BIT   2
`define IRQ_WIDTH        3
`define AC_PRESET        0
`define AC_SHIFT_RWB     1
`define AC_TB_TO_RWB     2
`define AC_ADD_TAC       3
`define AC_CLR_BLOCK     4
`define AC_BACKWARD      5
`define AC_UNIT1         6
`define AC_FORWARD       7
`define AC_WRITE_SYNC    8
`define AC_MOTION        9
`define AC_EIGHT_TAPE    10
`define AC_EIGHT_WRITE   11
`define SEL_LOAD_TB      4'h0
`define SEL_LOAD_TBN     4'h1
`define SEL_LOAD_TAC     4'h2
`define SEL_LOAD_TMA     4'h3
`define SEL_READ_SETUP   4'h4
`define SEL_READ_TBN     4'h5
`define SEL_READ_TB      4'h6
`define SEL_READ_RWB     4'h7
`define SEL_READ_CTL     4'h9
`define SEL_READ_UNITS   4'hA
`define SEL_READ_TMA     4'hE
`endif

// [hw/tape_maint_pkg.sv]
// Types shared by the tape maintenance port modules.
package tape_maint_pkg;
   typedef enum logic {BUS_WAIT, BUS_ACK} bus_phase_e;
   typedef logic [11:0] word_t;
   typedef struct packed {
      bus_phase_e phase;
      logic [31:0] rdata;
      logic        maint;
      logic [3:0]  mir;
      logic        done;
      logic        skip;
      logic        last_skip;
      logic        tp0;
      logic        tp3;
      logic        preset;
      logic [3:0]  sim;
      logic [3:0]  chan;
      word_t       tb;
      word_t       tbn;
      word_t       tape_accumulator_register;
      word_t       tma;
      word_t       read_write_buffer;
      logic        motion;
      logic        backward;
      logic        unit1;
      logic        write_sync;
      logic        eight_block;
      logic        eight_tape;
      logic        eight_write;
      logic [2:0]  irq_stat;
      logic [2:0]  irq_mask;
      logic        irq;
      logic [4:0]  s1;
      logic [4:0]  s2;
      logic [4:0]  s3;
      logic [4:0]  filt;
   } state_s;
endpackage

// [tb/cpu_model.sv]
// Processor model that issues maintenance instructions as register bus cycles.
`timescale 1ns/1ps
module cpu_model (
   input  wire logic        clk_i,
   input  wire logic [31:0] avs_readdata_i,
   input  wire logic        avs_waitrequest_i,
   output logic      [4:0]  avs_address_o,
   output logic             avs_read_o,
   output logic             avs_write_o,
   output logic      [31:0] avs_writedata_o,
   output logic      [3:0]  avs_byteenable_o
);
   initial begin
      avs_address_o = 5'h00;
      avs_read_o = 1'b0;
      avs_write_o = 1'b0;
      avs_writedata_o = 32'h0;
      avs_byteenable_o = 4'hF;
   end
   // Each call carries one plain instruction, never combined with another.
   task automatic acc(input logic [4:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk_i);
      avs_address_o <= a;
      avs_writedata_o <= d;
      avs_write_o <= w;
      avs_read_o <= !w;
      do @(posedge clk_i); while (avs_waitrequest_i !== 1'b0);
      q = avs_readdata_i;
      avs_write_o <= 1'b0;
      avs_read_o <= 1'b0;
      // Released lines are inverted so stale values are never mistaken for live ones.
      avs_address_o <= ~a;
      avs_writedata_o <= ~d;
   endtask
endmodule

// [tb/tape_control_maintenance_port_assertions.sv]
// Concurrent checks on the ports of the tape maintenance port.
`timescale 1ns/1ps
`include "tape_maint_defines.svh"
module tape_control_maintenance_port_assertions #(
   parameter bit EIGHT_MODE = 1'b1
) (
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic [4:0]  avs_address_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic        avs_waitrequest_o,
   input wire logic        timing_pulse_zero_o,
   input wire logic        timing_pulse_three_o,
   input wire logic        skip_o,
   input wire logic        tape_preset_o,
   input wire logic        motion_o,
   input wire logic        direction_o,
   input wire logic        unit1_sel_o,
   input wire logic        eight_tape_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire logic        ack = !avs_waitrequest_o;
   wire logic [31:0] wd  = avs_writedata_i;
   wire logic        fst = avs_write_i && ack && avs_address_i == `ADDR_IOT_FIRST;
   wire logic        snd = avs_write_i && ack && avs_address_i == `ADDR_IOT_SECOND;
   wire logic        xm  = snd && EIGHT_MODE;
   wire logic        t0  = fst && wd[5];
   wire logic        sk  = fst && wd[6];
   bus_answer_a: assert property ((avs_read_i || avs_write_i) && !ack |=> ack)
      else $error("bus answer late");
   zero_pulse_a: assert property (t0 |-> ##[1:2] timing_pulse_zero_o)
      else $error("timing pulse zero missing");
   three_pulse_a: assert property (fst && wd[4] |-> ##[1:2] timing_pulse_three_o)
      else $error("timing pulse three missing");
   zero_cause_a: assert property (timing_pulse_zero_o |-> $past(t0) || $past(t0, 2))
      else $error("timing pulse zero without cause");
   skip_cause_a: assert property (skip_o |-> $past(sk) || $past(sk, 2))
      else $error("skip without test");
   preset_pulse_a: assert property (snd && wd[11] |-> ##[1:2] tape_preset_o)
      else $error("preset pulse missing");
   backward_dir_a: assert property (xm && wd[6] && !wd[4] |-> ##[1:2] direction_o)
      else $error("backward not set");
   forward_dir_a: assert property (xm && wd[4] && !wd[6] |-> ##[1:2] !direction_o)
      else $error("forward not set");
   motion_set_a: assert property (xm && wd[2] |-> ##[1:2] motion_o)
      else $error("motion not set");
   unit_select_a: assert property (xm && wd[5] |-> ##[1:2] unit1_sel_o)
      else $error("unit one not selected");
   eight_tape_a: assert property (xm && wd[1] |-> ##[1:2] eight_tape_o)
      else $error("eight tape not selected");
   cover property (t0);
   cover property (xm && wd[2]);
   cover property (avs_read_i && ack);
endmodule
bind tape_control_maintenance_port tape_control_maintenance_port_assertions #(
   .EIGHT_MODE(EIGHT_MODE)) i_chk (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i,
   .avs_write_i, .avs_writedata_i, .avs_waitrequest_o, .timing_pulse_zero_o,
   .timing_pulse_three_o, .skip_o, .tape_preset_o, .motion_o, .direction_o,
   .unit1_sel_o, .eight_tape_o);

// [tb/tape_control_maintenance_port_bench.sv]
// Self-checking bench of the tape maintenance port.
`timescale 1ns/1ps
`include "tape_maint_defines.svh"
module tape_control_maintenance_port_bench;
   logic        clk_i, rst_n_i, ce_i, avs_read_i, avs_write_i, avs_waitrequest_o;
   logic [4:0]  avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o;
   logic [3:0]  avs_byteenable_i, seen;
   logic        xport_mark_i, xport_done_i, chan_mark_o, irq_o, skip_o, tape_preset_o;
   logic [2:0]  xport_data_i, chan_data_o;
   logic        timing_pulse_zero_o, timing_pulse_three_o, motion_o, direction_o;
   logic        unit1_sel_o, write_sync_o, eight_tape_o, eight_write_o;
   int          miscompares, samples_checked;
   tape_control_maintenance_port #(.EIGHT_MODE(1'b1)) i_dut (.clk_i, .rst_n_i, .ce_i,
      .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
      .avs_readdata_o, .avs_waitrequest_o, .xport_mark_i, .xport_data_i, .xport_done_i,
      .chan_mark_o, .chan_data_o, .timing_pulse_zero_o, .timing_pulse_three_o, .skip_o,
      .tape_preset_o, .motion_o, .direction_o, .unit1_sel_o, .write_sync_o,
      .eight_tape_o, .eight_write_o, .irq_o);
   cpu_model i_cpu (.clk_i, .avs_readdata_i(avs_readdata_o),
      .avs_waitrequest_i(avs_waitrequest_o), .avs_address_o(avs_address_i),
      .avs_read_o(avs_read_i), .avs_write_o(avs_write_i),
      .avs_writedata_o(avs_writedata_i), .avs_byteenable_o(avs_byteenable_i));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // One-cycle pulses are caught on the falling edge, away from the update edge.
   always @(negedge clk_i) seen = seen | {skip_o, timing_pulse_zero_o,
                                          timing_pulse_three_o, tape_preset_o};
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      i_cpu.acc(a, 1'b1, d, q);
   endtask
   task rc(input string n, input logic [4:0] a, input logic [31:0] e);
      logic [31:0] q;
      i_cpu.acc(a, 1'b0, 32'h0, q);
      chk(n, e, q);
   endtask
   task wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task t_reset;
      rc("ctrl reset", `ADDR_CTRL, 32'h0);
      rc("mask reset", `ADDR_IRQ_MASK, 32'h0);
      rc("status reset", `ADDR_STATUS, 32'h0);
      chk("irq reset", 32'h0, 32'(irq_o));
   endtask
   task t_pins;
      xport_mark_i <= 1'b1;
      xport_data_i <= 3'h7;
      xport_done_i <= 1'b1;
      wt(10);
      chk("chan pins", 32'hF, 32'({chan_mark_o, chan_data_o}));
      rc("done from pin", `ADDR_STATUS, 32'hF080);
      rc("done event", `ADDR_IRQ_STAT, 32'h1);
   endtask
   task t_first;
      wr(`ADDR_CTRL, 32'h1);
      seen = 4'h0;
      wr(`ADDR_IOT_FIRST, 32'h978);
      wt(4);
      chk("first pulses", 32'hE, 32'(seen));
      chk("sim levels", 32'h8, 32'({chan_mark_o, chan_data_o}));
      rc("skip taken", `ADDR_IOT_FIRST, 32'h1);
      rc("first status", `ADDR_STATUS, 32'h8889);
      seen = 4'h0;
      wr(`ADDR_IOT_FIRST, 32'h9C8);
      wt(4);
      chk("skip before clear", 32'h8, 32'(seen));
      rc("done cleared", `ADDR_STATUS, 32'h8809);
      seen = 4'h0;
      wr(`ADDR_IOT_FIRST, 32'h948);
      wt(4);
      chk("no skip", 32'h0, 32'(seen));
      rc("skip not taken", `ADDR_IOT_FIRST, 32'h0);
      xport_done_i <= 1'b0;
      wt(10);
      xport_done_i <= 1'b1;
      xport_mark_i <= 1'b0;
      wt(10);
      rc("pins blocked", `ADDR_STATUS, 32'h8809);
   endtask
   task t_second;
      logic [11:0] ac [12] = '{12'h004, 12'h040, 12'h004, 12'h010, 12'h020, 12'h008,
                               12'h002, 12'h001, 12'h080, 12'h800, 12'h040, 12'h004};
      logic [6:0]  ex [12] = '{7'h01, 7'h03, 7'h03, 7'h01, 7'h05, 7'h0D,
                               7'h2D, 7'h6D, 7'h6D, 7'h64, 7'h66, 7'h65};
      logic [31:0] q;
      for (int i = 0; i < 12; i++) begin
         seen = 4'h0;
         wr(`ADDR_IOT_SECOND, 32'(ac[i]));
         wt(3);
         i_cpu.acc(`ADDR_STATUS, 1'b0, 32'h0, q);
         chk("levels", 32'(ex[i]), 32'(q[22:16]));
         chk("level pins", 32'({ex[i][6:5], ex[i][3:0]}), 32'({eight_write_o, eight_tape_o,
             write_sync_o, unit1_sel_o, direction_o, motion_o}));
         chk("preset pulse", 32'(ac[i][11]), 32'(seen[0]));
      end
   endtask
   task t_xfer;
      wr(`ADDR_IOT_FIRST, 32'h000);
      wr(`ADDR_XFER, 32'h123);
      wr(`ADDR_IOT_SECOND, 32'h200);
      wr(`ADDR_IOT_FIRST, 32'h700);
      rc("buffer copy", `ADDR_XFER, 32'h123);
      wr(`ADDR_IOT_SECOND, 32'h400);
      rc("buffer shift", `ADDR_XFER, 32'h918);
      wr(`ADDR_IOT_FIRST, 32'h600);
      rc("tape buffer", `ADDR_XFER, 32'h123);
      wr(`ADDR_IOT_FIRST, 32'h200);
      wr(`ADDR_XFER, 32'hFF0);
      wr(`ADDR_IOT_FIRST, 32'h000);
      wr(`ADDR_XFER, 32'h00F);
      wr(`ADDR_IOT_SECOND, 32'h100);
      wr(`ADDR_IOT_FIRST, 32'h900);
      rc("tac all ones", `ADDR_XFER, 32'h800);
   endtask
   task t_irq;
      wr(`ADDR_IRQ_STAT, 32'h7);
      rc("irq cleared", `ADDR_IRQ_STAT, 32'h0);
      wr(`ADDR_IOT_SECOND, 32'h020);
      rc("control event", `ADDR_IRQ_STAT, 32'h2);
      chk("irq masked", 32'h0, 32'(irq_o));
      wr(`ADDR_IRQ_MASK, 32'h2);
      wt(2);
      chk("irq raised", 32'h1, 32'(irq_o));
      rc("mask readback", `ADDR_IRQ_MASK, 32'h2);
      wr(`ADDR_IRQ_STAT, 32'h2);
      wt(2);
      chk("irq dropped", 32'h0, 32'(irq_o));
      rc("second reads zero", `ADDR_IOT_SECOND, 32'h0);
      wr(5'h1C, 32'hFFF);
      rc("unmapped", 5'h1C, 32'h0);
      wr(`ADDR_CTRL, 32'h0);
      wt(2);
      ce_i <= 1'b0;
      xport_mark_i <= 1'b1;
      wt(10);
      chk("frozen by enable", 32'h7, 32'({chan_mark_o, chan_data_o}));
      ce_i <= 1'b1;
      wt(10);
      chk("pins after enable", 32'hF, 32'({chan_mark_o, chan_data_o}));
   endtask
   task results;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // The whole sequence needs well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge clk_i);
      miscompares++;
      $display("[FAIL] watchdog expected end seen hang");
      results;
   end
   initial begin
      rst_n_i = 1'b0;
      ce_i = 1'b1;
      xport_mark_i = 1'b0;
      xport_data_i = 3'h0;
      xport_done_i = 1'b0;
      miscompares = 0;
      samples_checked = 0;
      seen = 4'h0;
      repeat (5) @(posedge clk_i);
      chk("wait in reset", 32'h1, 32'(avs_waitrequest_o));
      rst_n_i <= 1'b1;
      t_reset;
      t_pins;
      t_first;
      t_second;
      t_xfer;
      t_irq;
      results;
   end
endmodule
